// [core/dlu_pkg.sv]
// Constants and types shared by the double-word load unit.
// Assumes a 32-bit integer datapath and a Wishbone register slave with byte addresses.
package dlu_pkg;

   // Instruction fields
   localparam logic [1:0] OP_MEMORY            = 2'h3;
   localparam logic [5:0] OP3_LOAD_PAIR_ALT    = 6'h13;
   localparam logic [5:0] OP3_LOAD_PAIR_COPROC = 6'h33;
   localparam int         OP_MSB     = 31;
   localparam int         OP_LSB     = 30;
   localparam int         RD_MSB     = 29;
   localparam int         RD_LSB     = 25;
   localparam int         OP3_MSB    = 24;
   localparam int         OP3_LSB    = 19;
   localparam int         BASE_MSB   = 18;
   localparam int         BASE_LSB   = 14;
   localparam int         IMM_SEL    = 13;
   localparam int         SPACE_MSB  = 12;
   localparam int         SPACE_LSB  = 5;
   localparam int         OFFS_MSB   = 4;
   localparam int         OFFS_LSB   = 0;
   localparam int         SIMM_MSB   = 12;
   localparam int         SIMM_W     = 13;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;

   // Register map (byte offsets)
   localparam int          WB_AW       = 8;
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [7:0]  REG_CLEAR   = 8'h08;
   localparam logic [7:0]  REG_IRQ_EN  = 8'h0C;
   localparam logic [7:0]  REG_INFO    = 8'h10;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
   localparam int          CTRL_ENABLE = 0;
   localparam int          EVT_W       = 3;
   localparam int          EVT_DONE    = 0;
   localparam int          EVT_TRAP    = 1;
   localparam int          EVT_STALL   = 2;
   localparam int          INFO_BUSY   = 8;

   typedef enum logic [2:0] {
      TRAP_NONE        = 3'h0,
      TRAP_ILLEGAL     = 3'h1,
      TRAP_PRIVILEGED  = 3'h2,
      TRAP_MISALIGNED  = 3'h3,
      TRAP_DATA_ACCESS = 3'h4,
      TRAP_COPROC_OFF  = 3'h5
   } dlu_trap_type;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_HI   = 3'h2,
      S_LO   = 3'h4
   } dlu_state_type;

endpackage

// [core/dlu_addr_gen.sv]
// Effective-address former for the double-word loads.
// Assumes register values are read in the same cycle as the indices are presented.
`timescale 1ns/1ps
module dlu_addr_gen
   import dlu_pkg::*;
#(
   parameter int AW = 32
) (
   input  wire logic [4:0]        base_index,
   input  wire logic [AW-1:0]     base_value,
   input  wire logic [AW-1:0]     offset_value,
   input  wire logic              imm_select,
   input  wire logic [SIMM_W-1:0] short_immediate,
   output      logic [AW-1:0]     eff_addr,
   output      logic              misaligned
);
   logic [AW-1:0] base_eff;
   logic [AW-1:0] operand;

   // Register zero reads as zero, so the immediate alone reaches either end
   assign base_eff = (base_index == 5'h00) ? '0 : base_value;
   // Offset register or sign-extended immediate
   assign operand  = imm_select ? {{(AW-SIMM_W){short_immediate[SIMM_MSB]}}, short_immediate}
                                : offset_value;
   assign eff_addr   = base_eff + operand;
   // A pair must sit on an eight-byte boundary
   assign misaligned = |eff_addr[2:0];
endmodule

// [core/dlu_core.sv]
// Double-word load unit: alternate-space and coprocessor pair loads.
// Assumes a same-clock memory port with ack and fault, and a register file that writes a pair at once.
//
// Overview of operation
// - Alternate pair load decodes as op 11, op3 010011; fixed field positions.
// - Alternate pair load fetches 64 bits into destination and the register above.
// - Memory sees the instruction's space identifier and base plus offset address.
// - High word at address goes to even register, low word at address+4 to odd.
// - Any trap during the alternate load's access leaves both destinations unchanged.
// - Instruction reading a pending load destination stalls at least one cycle.
// - Alternate pair load stall check covers both registers of the pair.
// - Coprocessor pair address is base plus offset register or sign-extended immediate.
// - Coprocessor pair load traps disabled when enable bit clear or no coprocessor.
// - Use right after a coprocessor load is delayed by one or more cycles.
// - Coprocessor pair interlock covers both coprocessor registers.
// - No coprocessor port here; every coprocessor pair load takes the disabled trap.
// - Base index zero with immediate addresses lowest or highest 4 Kbytes.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module dlu_core
   import dlu_pkg::*;
#(
   parameter int         AW              = 32,
   parameter logic [7:0] DATA_SPACE      = 8'h00,
   parameter bit         COPROC_PRESENT  = 1'b0
) (
   input  wire logic             CORE_CLK,
   input  wire logic             RST,
   input  wire logic             WB_CYC_I,
   input  wire logic             WB_STB_I,
   input  wire logic             WB_WE_I,
   input  wire logic [WB_AW-1:0] WB_ADR_I,
   input  wire logic [3:0]       WB_SEL_I,
   input  wire logic [31:0]      WB_DAT_I,
   output      logic [31:0]      WB_DAT_O,
   output      logic             WB_ACK_O,
   output      logic             IRQ,
   input  wire logic [31:0]      INSN,
   input  wire logic             INSN_VALID,
   output      logic             INSN_READY,
   input  wire logic             SUPERVISOR,
   input  wire logic             COPROC_ENABLE_BIT,
   output      logic [4:0]       BASE_REG_INDEX,
   output      logic [4:0]       OFFSET_REG_INDEX,
   input  wire logic [AW-1:0]    BASE_VALUE,
   input  wire logic [AW-1:0]    OFFSET_VALUE,
   input  wire logic [4:0]       NEXT_SRC1,
   input  wire logic [4:0]       NEXT_SRC2,
   output      logic             STALL,
   output      logic             MEM_REQ,
   output      logic [AW-1:0]    MEM_ADDR,
   output      logic [7:0]       MEM_ASI,
   input  wire logic             MEM_ACK,
   input  wire logic [31:0]      MEM_RDATA,
   input  wire logic             MEM_FAULT,
   output      logic             WR_EN,
   output      logic [4:0]       WR_INDEX,
   output      logic [31:0]      WR_DATA_EVEN,
   output      logic [31:0]      WR_DATA_ODD,
   output      logic             TRAP,
   output      dlu_trap_type     TRAP_CODE
);
   dlu_state_type   st_q;
   dlu_trap_type    trap_d;
   dlu_trap_type    last_trap_q;
   logic [AW-1:0]   eff_addr;
   logic            misaligned;
   logic            is_alt;
   logic            is_coproc;
   logic            issue;
   logic            start;
   logic [4:0]      dest_q;
   logic [31:0]     hi_word_q;
   logic [AW-1:0]   addr_q;
   logic [7:0]      asi_q;
   logic            wr_en_q;
   logic [31:0]     wr_even_q;
   logic [31:0]     wr_odd_q;
   logic [4:0]      wr_index_q;
   logic            trap_q;
   dlu_trap_type    trap_code_q;
   logic            fault_trap;
   logic            stall_q;
   logic [31:0]     ctrl_q;
   logic [EVT_W-1:0] status_q;
   logic [EVT_W-1:0] irq_en_q;
   logic [EVT_W-1:0] evt;
   logic [EVT_W-1:0] clr;
   logic            ack_q;
   logic [31:0]     rdata_q;
   logic            wb_req;
   logic            wb_wr;

   // Decode of the two pair loads
   assign is_alt    = (INSN[OP_MSB:OP_LSB] == OP_MEMORY)
                    && (INSN[OP3_MSB:OP3_LSB] == OP3_LOAD_PAIR_ALT);
   assign is_coproc = (INSN[OP_MSB:OP_LSB] == OP_MEMORY)
                    && (INSN[OP3_MSB:OP3_LSB] == OP3_LOAD_PAIR_COPROC);
   assign BASE_REG_INDEX   = INSN[BASE_MSB:BASE_LSB];
   assign OFFSET_REG_INDEX = INSN[OFFS_MSB:OFFS_LSB];
   assign INSN_READY = (st_q == S_IDLE) && ctrl_q[CTRL_ENABLE];
   assign issue      = INSN_VALID && INSN_READY;

   dlu_addr_gen #(.AW(AW)) u_addr (
      .base_index      (INSN[BASE_MSB:BASE_LSB]),
      .base_value      (BASE_VALUE),
      .offset_value    (OFFSET_VALUE),
      .imm_select      (INSN[IMM_SEL]),
      .short_immediate (INSN[SIMM_MSB:0]),
      .eff_addr        (eff_addr),
      .misaligned      (misaligned)
   );

   // Trap priority at issue: encoding, privilege, then alignment
   always_comb begin
      trap_d = TRAP_NONE;
      if (issue && is_alt) begin
         if (INSN[IMM_SEL])
            trap_d = TRAP_ILLEGAL;
         else if (!SUPERVISOR)
            trap_d = TRAP_PRIVILEGED;
         else if (misaligned)
            trap_d = TRAP_MISALIGNED;
      end else if (issue && is_coproc) begin
         // No coprocessor port, so the enable bit alone cannot open this path
         if (!COPROC_ENABLE_BIT || !COPROC_PRESENT || 1'b1)
            trap_d = TRAP_COPROC_OFF;
      end
   end
   assign start      = issue && is_alt && (trap_d == TRAP_NONE);
   assign fault_trap = (st_q != S_IDLE) && MEM_ACK && MEM_FAULT;

   // Pair load sequencer: high word, then low word
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_q <= S_IDLE;
      end else begin
         unique case (st_q)
            S_IDLE: if (start) st_q <= S_HI;
            S_HI: begin
               if (MEM_ACK) st_q <= MEM_FAULT ? S_IDLE : S_LO;
            end
            S_LO: if (MEM_ACK) st_q <= S_IDLE;
         endcase
      end
   end

   // Memory request: space identifier and address held until ack
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         addr_q <= '0;
         asi_q  <= 8'h00;
         dest_q <= 5'h00;
      end else if (start) begin
         addr_q <= eff_addr;
         asi_q  <= INSN[SPACE_MSB:SPACE_LSB];
         dest_q <= {INSN[RD_MSB:RD_LSB+1], 1'b0};
      end else if (st_q == S_HI && MEM_ACK && !MEM_FAULT) begin
         addr_q <= addr_q + WORD_STEP;
      end else if (st_q == S_IDLE) begin
         asi_q  <= DATA_SPACE;
      end
   end
   assign MEM_REQ  = (st_q != S_IDLE);
   assign MEM_ADDR = addr_q;
   assign MEM_ASI  = asi_q;

   // High word waits; nothing reaches the register file until both words are clean
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         hi_word_q  <= 32'h0000_0000;
         wr_en_q    <= 1'b0;
         wr_even_q  <= 32'h0000_0000;
         wr_odd_q   <= 32'h0000_0000;
         wr_index_q <= 5'h00;
      end else begin
         wr_en_q <= 1'b0;
         if (st_q == S_HI && MEM_ACK && !MEM_FAULT)
            hi_word_q <= MEM_RDATA;
         if (st_q == S_LO && MEM_ACK && !MEM_FAULT) begin
            wr_en_q    <= 1'b1;
            wr_even_q  <= hi_word_q;
            wr_odd_q   <= MEM_RDATA;
            wr_index_q <= dest_q;
         end
      end
   end
   assign WR_EN        = wr_en_q;
   assign WR_INDEX     = wr_index_q;
   assign WR_DATA_EVEN = wr_even_q;
   assign WR_DATA_ODD  = wr_odd_q;

   // Trap report, one cycle after the cause
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         trap_q      <= 1'b0;
         trap_code_q <= TRAP_NONE;
         last_trap_q <= TRAP_NONE;
      end else begin
         trap_q <= 1'b0;
         if (fault_trap) begin
            trap_q      <= 1'b1;
            trap_code_q <= TRAP_DATA_ACCESS;
            last_trap_q <= TRAP_DATA_ACCESS;
         end else if (trap_d != TRAP_NONE) begin
            trap_q      <= 1'b1;
            trap_code_q <= trap_d;
            last_trap_q <= trap_d;
         end
      end
   end
   assign TRAP      = trap_q;
   assign TRAP_CODE = trap_code_q;

   // Load-use interlock on either register of the pending pair. Coprocessor
   // loads never become pending because they always trap here.
   assign STALL = (st_q != S_IDLE)
                && ((NEXT_SRC1[4:1] == dest_q[4:1]) || (NEXT_SRC2[4:1] == dest_q[4:1]));

   always_ff @(posedge CORE_CLK) begin
      if (RST) stall_q <= 1'b0;
      else     stall_q <= STALL;
   end

   // Events: pair written, trap taken, stall begun
   assign evt[EVT_DONE]  = wr_en_q;
   assign evt[EVT_TRAP]  = trap_q;
   assign evt[EVT_STALL] = STALL && !stall_q;

   // Wishbone slave: ack one cycle after the strobe, dropped the next
   assign wb_req = WB_CYC_I && WB_STB_I && !ack_q;
   // Writes land on the edge that also sees ack, so an aborted cycle changes nothing
   assign wb_wr  = WB_CYC_I && WB_STB_I && ack_q && WB_WE_I && WB_SEL_I[0];
   assign clr    = (wb_wr && WB_ADR_I == REG_CLEAR) ? WB_DAT_I[EVT_W-1:0] : '0;
   always_ff @(posedge CORE_CLK) begin
      if (RST) ack_q <= 1'b0;
      else     ack_q <= wb_req;
   end

   // Control and enable registers
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_q   <= CTRL_RESET;
         irq_en_q <= '0;
      end else if (wb_wr) begin
         if (WB_ADR_I == REG_CTRL)   ctrl_q   <= {31'h0000_0000, WB_DAT_I[CTRL_ENABLE]};
         if (WB_ADR_I == REG_IRQ_EN) irq_en_q <= WB_DAT_I[EVT_W-1:0];
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK) begin
      if (RST) status_q <= '0;
      else     status_q <= (status_q & ~clr) | evt;
   end
   assign IRQ = |(status_q & irq_en_q);

   // Read data; unmapped and write-only offsets read zero
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rdata_q <= 32'h0000_0000;
      end else if (wb_req && !WB_WE_I) begin
         unique case (WB_ADR_I)
            REG_CTRL:   rdata_q <= ctrl_q;
            REG_STATUS: rdata_q <= {29'h0000_0000, status_q};
            REG_IRQ_EN: rdata_q <= {29'h0000_0000, irq_en_q};
            REG_INFO:   rdata_q <= {23'h00_0000, (st_q != S_IDLE), 5'h00, last_trap_q};
            default:    rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign WB_DAT_O = rdata_q;
   assign WB_ACK_O = ack_q;

   // Checks
   a_alt_request: assert property (@(posedge CORE_CLK) disable iff (RST)
      start |=> MEM_REQ && MEM_ASI == $past(INSN[SPACE_MSB:SPACE_LSB]) && MEM_ADDR == $past(eff_addr))
      else $error("alternate request lacks space or address");
   a_pair_write_cause: assert property (@(posedge CORE_CLK) disable iff (RST)
      WR_EN |-> $past(st_q == S_LO && MEM_ACK && !MEM_FAULT))
      else $error("pair written without clean low word");
   a_word_order: assert property (@(posedge CORE_CLK) disable iff (RST)
      (st_q == S_HI && MEM_ACK && !MEM_FAULT)
      |=> MEM_ADDR == $past(MEM_ADDR) + WORD_STEP && hi_word_q == $past(MEM_RDATA))
      else $error("high word or next address wrong");
   a_odd_word: assert property (@(posedge CORE_CLK) disable iff (RST)
      (st_q == S_LO && MEM_ACK && !MEM_FAULT)
      |=> WR_EN && WR_DATA_EVEN == $past(hi_word_q) && WR_DATA_ODD == $past(MEM_RDATA) && WR_INDEX[0] == 1'b0)
      else $error("word order into pair wrong");
   a_fault_no_write: assert property (@(posedge CORE_CLK) disable iff (RST)
      fault_trap |=> TRAP && TRAP_CODE == TRAP_DATA_ACCESS && !WR_EN && !MEM_REQ)
      else $error("fault did not cancel pair write");
   a_stall_pair: assert property (@(posedge CORE_CLK) disable iff (RST)
      (MEM_REQ && (NEXT_SRC1 == (dest_q | 5'h01) || NEXT_SRC2 == dest_q)) |-> STALL)
      else $error("stall missed a pair register");
   a_illegal_imm: assert property (@(posedge CORE_CLK) disable iff (RST)
      (issue && is_alt && INSN[IMM_SEL]) |=> TRAP && TRAP_CODE == TRAP_ILLEGAL && !MEM_REQ)
      else $error("immediate form not illegal");
   a_user_priv: assert property (@(posedge CORE_CLK) disable iff (RST)
      (issue && is_alt && !INSN[IMM_SEL] && !SUPERVISOR) |=> TRAP && TRAP_CODE == TRAP_PRIVILEGED)
      else $error("user mode not privileged trap");
   a_coproc_off: assert property (@(posedge CORE_CLK) disable iff (RST)
      (issue && is_coproc) |=> TRAP && TRAP_CODE == TRAP_COPROC_OFF && !MEM_REQ)
      else $error("coprocessor load not disabled");
   a_misaligned: assert property (@(posedge CORE_CLK) disable iff (RST)
      (issue && is_alt && !INSN[IMM_SEL] && SUPERVISOR && misaligned)
      |=> TRAP && TRAP_CODE == TRAP_MISALIGNED && !MEM_REQ ##1 !WR_EN)
      else $error("misaligned pair not trapped");
   a_wb_ack_drop: assert property (@(posedge CORE_CLK) disable iff (RST)
      WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held beyond one cycle");
endmodule

// [sim/dlu_mem_model.sv]
// Memory subsystem model for the double-word load unit bench.
// Assumes a level request held with a stable address until one ack pulse.
`timescale 1ns/1ps
module dlu_mem_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        req,
   input  wire logic [31:0] addr,
   input  wire logic [3:0]  wait_cycles,
   input  wire logic [31:0] fault_addr,
   output      logic        ack,
   output      logic [31:0] rdata,
   output      logic        fault
);
   logic [3:0] cnt_q;

   // Wait states set here decide the load-use stall length
   always_ff @(posedge clk) begin
      if (rst) begin
         ack   <= 1'b0;
         cnt_q <= 4'h0;
      end else if (req && !ack && cnt_q >= wait_cycles) begin
         ack   <= 1'b1;
         cnt_q <= 4'h0;
      end else begin
         ack   <= 1'b0;
         cnt_q <= req && !ack ? cnt_q + 4'h1 : 4'h0;
      end
   end

   // Data and fault only mean something with ack; otherwise they toggle
   always_ff @(posedge clk) begin
      if (req && !ack && cnt_q >= wait_cycles) begin
         rdata <= {~addr[15:0], addr[15:0]};
         fault <= addr == fault_addr;
      end else begin
         rdata <= ~rdata;
         fault <= ~fault;
      end
   end
endmodule

// [sim/double_word_load_alt_coproc_tb_top.sv]
// Self-checking bench for the double-word load unit.
// Assumes dlu_core and the memory model; the Wishbone master and instruction feed live here.
`timescale 1ns/1ps
module double_word_load_alt_coproc_tb_top;
   import dlu_pkg::*;
   logic CORE_CLK = 1'b0, RST = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
   logic [7:0] WB_ADR_I = 8'h00;
   logic [3:0] WB_SEL_I = 4'hF;
   logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, INSN = 32'h0, BASE_VALUE = 32'h0, OFFSET_VALUE = 32'h0;
   logic [31:0] MEM_ADDR, MEM_RDATA, WR_DATA_EVEN, WR_DATA_ODD, fault_addr = 32'hFFFF_FFFF;
   logic WB_ACK_O, IRQ, INSN_VALID = 1'b0, INSN_READY, SUPERVISOR = 1'b1, COPROC_ENABLE_BIT = 1'b0;
   logic STALL, MEM_REQ, MEM_ACK, MEM_FAULT, WR_EN, TRAP;
   logic [4:0] BASE_REG_INDEX, OFFSET_REG_INDEX, NEXT_SRC1 = 5'h0, NEXT_SRC2 = 5'h0, WR_INDEX;
   logic [7:0] MEM_ASI;
   logic [3:0] wait_cycles = 4'h0;
   dlu_trap_type TRAP_CODE;
   int n_errors = 0, n_checks = 0, seed = 33;

   dlu_core u_dut (.CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
      .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
      .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ), .INSN(INSN), .INSN_VALID(INSN_VALID),
      .INSN_READY(INSN_READY), .SUPERVISOR(SUPERVISOR), .COPROC_ENABLE_BIT(COPROC_ENABLE_BIT),
      .BASE_REG_INDEX(BASE_REG_INDEX), .OFFSET_REG_INDEX(OFFSET_REG_INDEX), .BASE_VALUE(BASE_VALUE),
      .OFFSET_VALUE(OFFSET_VALUE), .NEXT_SRC1(NEXT_SRC1), .NEXT_SRC2(NEXT_SRC2), .STALL(STALL),
      .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ASI(MEM_ASI), .MEM_ACK(MEM_ACK),
      .MEM_RDATA(MEM_RDATA), .MEM_FAULT(MEM_FAULT), .WR_EN(WR_EN), .WR_INDEX(WR_INDEX),
      .WR_DATA_EVEN(WR_DATA_EVEN), .WR_DATA_ODD(WR_DATA_ODD), .TRAP(TRAP), .TRAP_CODE(TRAP_CODE));
   dlu_mem_model u_mem (.clk(CORE_CLK), .rst(RST), .req(MEM_REQ), .addr(MEM_ADDR),
      .wait_cycles(wait_cycles), .fault_addr(fault_addr), .ack(MEM_ACK), .rdata(MEM_RDATA),
      .fault(MEM_FAULT));

   // 20 MHz core clock
   always #25 CORE_CLK = ~CORE_CLK;

   task automatic check(input bit ok, input string msg);
      n_checks++;
      if (!ok) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Classic single Wishbone cycle; request held until the edge that sees ack
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
      int k;
      k = 0;
      @(posedge CORE_CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I  <= we;
      WB_ADR_I <= adr;
      WB_DAT_I <= wdat;
      do begin
         @(posedge CORE_CLK);
         k++;
      end while (WB_ACK_O !== 1'b1 && k < 50);
      check(WB_ACK_O === 1'b1, "bus ack missing");
      rdat = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
   endtask

   function automatic logic [31:0] word(input logic [31:0] a);
      return {~a[15:0], a[15:0]};
   endfunction

   function automatic logic [31:0] alt(input logic [4:0] rd, bi, oi, input logic [7:0] asi, input logic i);
      return {OP_MEMORY, rd, OP3_LOAD_PAIR_ALT, bi, i, asi, oi};
   endfunction

   // Issue one instruction, then watch memory, stall, write and trap until it ends
   task automatic run(input logic [31:0] insn, base, off, faddr, input logic sup, input dlu_trap_type code,
                      input bit hit);
      logic [31:0] a;
      logic [4:0]  rd;
      int          n_ack;
      bit          fin;
      rd = insn[29:25];
      a = (insn[18:14] == 5'h00 ? 32'h0 : base) + off;
      n_ack = 0;
      fin = 0;
      @(posedge CORE_CLK);
      INSN <= insn;
      INSN_VALID <= 1'b1;
      BASE_VALUE <= base;
      OFFSET_VALUE <= off;
      SUPERVISOR <= sup;
      fault_addr <= faddr;
      COPROC_ENABLE_BIT <= ~COPROC_ENABLE_BIT;
      wait_cycles <= 4'($random(seed));
      NEXT_SRC1 <= hit ? (rd | 5'h01) : ~rd;
      NEXT_SRC2 <= ~rd;
      do @(posedge CORE_CLK); while (INSN_READY !== 1'b1);
      INSN_VALID <= 1'b0;
      check(BASE_REG_INDEX === insn[18:14] && OFFSET_REG_INDEX === insn[4:0], "register indices");
      for (int k = 0; k < 300 && !fin; k++) begin
         @(negedge CORE_CLK);
         if (STALL !== (MEM_REQ & hit)) check(0, "stall mismatch");
         if (MEM_REQ === 1'b1 && MEM_ACK === 1'b1) begin
            check(MEM_ADDR === a + 32'(n_ack * 4) && MEM_ASI === insn[12:5], "address or space");
            n_ack++;
         end
         if (WR_EN === 1'b1) begin
            check(code == TRAP_NONE && WR_INDEX === (rd & 5'h1E), "pair index");
            check(WR_DATA_EVEN === word(a) && WR_DATA_ODD === word(a + 32'h4), "word order");
            fin = 1;
         end
         if (TRAP === 1'b1) begin
            check(TRAP_CODE === code, "trap code");
            fin = 1;
         end
      end
      check(fin && n_ack == ((code == TRAP_NONE || code == TRAP_DATA_ACCESS) ? 2 : 0), "access count");
      @(negedge CORE_CLK);
      check(WR_EN !== 1'b1, "late pair write");
   endtask

   initial begin
      logic [31:0] r;
      repeat (20) @(posedge CORE_CLK);
      RST <= 1'b0;
      wb(1'b0, REG_CTRL, 32'h0, r);
      check(r === CTRL_RESET, "control reset value");
      wb(1'b0, 8'h40, 32'h0, r);
      check(r === 32'h0, "unmapped read");
      wb(1'b1, REG_CTRL, 32'h0, r);
      @(negedge CORE_CLK);
      check(INSN_READY === 1'b0, "disabled still ready");
      wb(1'b1, REG_CTRL, 32'h1, r);
      wb(1'b1, REG_IRQ_EN, 32'h1, r);
      $display("test registers done");
      // Random clean loads, base index zero hit now and then
      for (int n = 0; n < 16; n++)
         run(alt(5'($random(seed)), n[1:0] == 0 ? 5'h0 : 5'($random(seed)), 5'($random(seed)),
                 8'($random(seed)), 1'b0),
             $random(seed) & 32'hFFFF_FFF8, $random(seed) & 32'hFFFF_FFF8, 32'hFFFF_FFFF, 1'b1, TRAP_NONE,
             1'($random(seed)));
      @(negedge CORE_CLK);
      check(IRQ === 1'b1, "irq after pair write");
      wb(1'b1, REG_CLEAR, 32'h7, r);
      @(negedge CORE_CLK);
      check(IRQ === 1'b0, "irq after clear");
      wb(1'b1, REG_IRQ_EN, 32'h0, r);
      $display("test random loads done");
      // Hand-made trap cases, then coprocessor loads with either enable value
      run(alt(5'h4, 5'h3, 5'h2, 8'hA5, 1'b1), 32'h100, 32'h20, 32'hFFFF_FFFF, 1'b0, TRAP_ILLEGAL, 1'b1);
      run(alt(5'h5, 5'h3, 5'h2, 8'h5A, 1'b0), 32'h100, 32'h20, 32'hFFFF_FFFF, 1'b0, TRAP_PRIVILEGED, 1'b0);
      run(alt(5'h6, 5'h3, 5'h2, 8'h11, 1'b0), 32'h100, 32'h24, 32'hFFFF_FFFF, 1'b1, TRAP_MISALIGNED, 1'b1);
      run(alt(5'h7, 5'h3, 5'h2, 8'hF0, 1'b0), 32'h100, 32'h20, 32'h124, 1'b1, TRAP_DATA_ACCESS, 1'b1);
      // Enable bit toggles per run; coprocessor register state after the trap is not judged
      for (int n = 0; n < 2; n++)
         run({OP_MEMORY, 5'h8, OP3_LOAD_PAIR_COPROC, 5'h0, 1'b1, 13'($random(seed))}, 32'h0, 32'h0,
             32'hFFFF_FFFF, 1'b1, TRAP_COPROC_OFF, 1'b0);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check(r[EVT_DONE] === 1'b0 && r[EVT_TRAP] === 1'b1 && IRQ === 1'b0, "masked status");
      wb(1'b0, REG_INFO, 32'h0, r);
      check(r[2:0] === 3'(TRAP_COPROC_OFF) && r[INFO_BUSY] === 1'b0, "last trap info");
      $display("test traps done");
      summarize();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge CORE_CLK);
      n_errors++;
      summarize();
   end
endmodule
